//--- tb_top.sv
// bench driving packets through the transport stream output
`timescale 1ns/1ps
module tb_top;
   logic core_clk_i = 0, rstn_i = 0, ts_link_clk_i = 0, in_valid_i = 0, serial_mode_i = 0;
   logic with_redundancy_i = 0, pll_divider_strap_i = 0, in_ready_o, pll_divider_sel_o;
   logic ts_data_clock_o, ts_byte_start_o, packet_valid_window_o, packet_error_flag_o;
   logic ts_msb_or_serial_line_o, rx_err;
   logic [6:0] ts_parallel_low_bits_o;
   logic [7:0] rx_first, rx_last, rx_cnt;
   tso_pkg::tso_byte_t in_byte_i = tso_pkg::TSO_BYTE_RST;
   int n_fail = 0, samples_checked = 0, cyc = 0;
   tso_output u_dut (
      .core_clk_i              (core_clk_i),
      .rstn_i                  (rstn_i),
      .ts_link_clk_i           (ts_link_clk_i),
      .in_valid_i              (in_valid_i),
      .in_ready_o              (in_ready_o),
      .in_byte_i               (in_byte_i),
      .serial_mode_i           (serial_mode_i),
      .with_redundancy_i       (with_redundancy_i),
      .pll_divider_strap_i     (pll_divider_strap_i),
      .pll_divider_sel_o       (pll_divider_sel_o),
      .ts_data_clock_o         (ts_data_clock_o),
      .ts_byte_start_o         (ts_byte_start_o),
      .packet_valid_window_o   (packet_valid_window_o),
      .packet_error_flag_o     (packet_error_flag_o),
      .ts_msb_or_serial_line_o (ts_msb_or_serial_line_o),
      .ts_parallel_low_bits_o  (ts_parallel_low_bits_o)
   );
   tso_rx_model u_rx (.data_clk_i(ts_data_clock_o), .ser_i(serial_mode_i),
      .msb_i(ts_msb_or_serial_line_o), .start_i(ts_byte_start_o), .err_i(packet_error_flag_o),
      .low_i(ts_parallel_low_bits_o), .first_o(rx_first), .last_o(rx_last), .cnt_o(rx_cnt),
      .err_o(rx_err));
   initial forever #2 core_clk_i = ~core_clk_i;
   initial
   begin
      #1.3;
      forever #80 ts_link_clk_i = ~ts_link_clk_i;
   end
   task automatic tally_and_finish;
      if (n_fail == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge core_clk_i)
      if (++cyc == 40000)
      begin
         n_fail++;
         tally_and_finish();
      end
   task automatic chk(input string nm, input logic [7:0] got, exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // tag is {first, last, parity, err}
   task automatic send(input logic [7:0] d, input logic [3:0] tag);
      int k = 0;
      while (in_ready_o !== 1'b1 && k++ < 999) @(negedge core_clk_i);
      chk("in_ready", {7'h00, in_ready_o}, 8'h01);
      in_byte_i = {d, tag};
      in_valid_i = 1;
      @(negedge core_clk_i);
      in_valid_i = 0;
   endtask : send
   task automatic t_strap(input logic v);
      rstn_i = 0;
      pll_divider_strap_i = v;
      repeat (6) @(negedge core_clk_i);
      rstn_i = 1;
      repeat (20) @(negedge core_clk_i);
      chk("div_sel", {7'h00, pll_divider_sel_o}, {7'h00, v});
   endtask : t_strap
   task automatic t_packet(input logic s, r, e, input logic [7:0] f);
      logic [7:0] c0;
      serial_mode_i = s;
      with_redundancy_i = r;
      repeat (200) @(negedge core_clk_i);
      c0 = rx_cnt;
      send(f, {3'b100, e});
      send(8'h3c, 4'h0);
      send(8'hc3, 4'h4);
      send(8'h5a, 4'h2);
      repeat (3000) @(negedge core_clk_i);
      chk("rx_count", rx_cnt - c0, 8'h03 + {7'h00, r});
      chk("first_byte", rx_first, f);
      chk("last_byte", rx_last, r ? 8'h5a : 8'hc3);
      chk("err_flag", {7'h00, rx_err}, {7'h00, e});
      chk("window_idle", {7'h00, packet_valid_window_o}, 8'h00);
   endtask : t_packet
   initial
   begin
      t_strap(1'b1);
      t_strap(tso_pkg::TSO_DIV_25MHZ);
      for (int i = 0; i < 4; i++)
         t_packet(i[1], i[0], i[0] ^ i[1], 8'h47 + 8'(i));
      tally_and_finish();
   end
endmodule : tb_top

//--- tso_output.sv
// transport stream output port: byte handoff, framing, serialiser, strap capture
`timescale 1ns/1ps

module tso_output
(
   // core clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              rstn_i,
   // link clock
   input  wire logic              ts_link_clk_i,
   // byte source, core domain
   input  wire logic              in_valid_i,
   output logic                   in_ready_o,
   input  wire tso_pkg::tso_byte_t in_byte_i,
   // mode selects, core domain levels
   input  wire logic              serial_mode_i,
   input  wire logic              with_redundancy_i,
   // divider strap and captured default
   input  wire logic              pll_divider_strap_i,
   output logic                   pll_divider_sel_o,
   // transport stream pins
   output logic                   ts_data_clock_o,
   output logic                   ts_byte_start_o,
   output logic                   packet_valid_window_o,
   output logic                   packet_error_flag_o,
   output logic                   ts_msb_or_serial_line_o,
   output logic [6:0]             ts_parallel_low_bits_o
);

   // state of each clock domain and its next value
   tso_pkg::tso_core_t core_q;
   tso_pkg::tso_core_t core_d;
   tso_pkg::tso_link_t link_q;
   tso_pkg::tso_link_t link_d;
   // link-side view of the byte held in the core domain
   tso_pkg::tso_byte_t nb;
   logic               new_avail;
   logic               byte_shown;
   logic               ser_shifting;
   logic               pkt_gap;

   // core domain: one byte in flight over a toggle handshake
   always_comb
   begin
      core_d        = core_q;
      core_d.ack_s1 = link_q.ack_tgl;
      core_d.ack_s2 = core_q.ack_s1;
      // strap sampled through two flops, captured once after reset release
      core_d.strap_s1  = pll_divider_strap_i;
      core_d.strap_s2  = core_q.strap_s1;
      // arm bits mark when the second flop holds a real pin sample
      core_d.strap_arm = {core_q.strap_arm[0], 1'b1};
      if (!core_q.strap_done)
      begin
         core_d.div_sel    = core_q.strap_s2;
         // done once the synced sample equals the previous one in div_sel (the first compare sees the reset value); first flop never read here
         core_d.strap_done = core_q.strap_arm[1] && (core_q.strap_s2 == core_q.div_sel);
      end
      // ack toggle caught up with the request: link has taken the byte
      if (core_q.busy && (core_q.ack_s2 == core_q.req_tgl))
      begin
         core_d.busy = 1'b0;
      end
      // a new byte is taken only while nothing is in flight
      if (in_valid_i && !core_q.busy)
      begin
         core_d.hold    = in_byte_i;
         core_d.req_tgl = ~core_q.req_tgl;
         core_d.busy    = 1'b1;
      end
   end

   // core flops
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         core_q <= '{hold:       tso_pkg::TSO_BYTE_RST,
                     req_tgl:    1'b0,
                     ack_s1:     1'b0,
                     ack_s2:     1'b0,
                     busy:       1'b0,
                     strap_s1:   1'b0,
                     strap_s2:   1'b0,
                     strap_arm:  tso_pkg::TSO_ARM_RST,
                     strap_done: 1'b0,
                     div_sel:    tso_pkg::TSO_DIV_25MHZ};
      end
      else
      begin
         core_q <= core_d;
      end
   end

   // ready straight from the busy flop
   assign in_ready_o        = ~core_q.busy;
   assign pll_divider_sel_o = core_q.div_sel;

   // held byte is stable while the request toggle differs from the ack
   assign nb        = core_q.hold;
   assign new_avail = link_q.req_s2 != link_q.ack_tgl;

   // a dropped redundancy byte is consumed with no clock pulse
   assign byte_shown   = !nb.parity || link_q.red_s2;
   // bits of the current serial byte still to go
   assign ser_shifting = link_q.bit_cnt != tso_pkg::TSO_CNT_ZERO;
   // back-to-back packets: window drops one cycle before the next first byte
   assign pkt_gap      = link_q.last && link_q.valid && nb.first;

   // link domain: present bytes, shift serial bits, frame packets
   always_comb
   begin
      link_d        = link_q;
      link_d.req_s1 = core_q.req_tgl;
      link_d.req_s2 = link_q.req_s1;
      // modes are levels; change them only while the port is idle
      link_d.ser_s1 = serial_mode_i;
      link_d.ser_s2 = link_q.ser_s1;
      link_d.red_s1 = with_redundancy_i;
      link_d.red_s2 = link_q.red_s1;
      // no pulse unless this cycle presents a bit or byte
      link_d.clk_en = 1'b0;
      if (ser_shifting)
      begin
         // remaining bits of the current serial byte
         link_d.data[7] = link_q.shreg[7];
         link_d.shreg   = {link_q.shreg[6:0], 1'b0};
         link_d.bit_cnt = link_q.bit_cnt - tso_pkg::TSO_CNT_STEP;
         link_d.clk_en  = 1'b1;
      end
      else if (new_avail && !pkt_gap)
      begin
         // byte consumed: let the core refill its hold register
         link_d.ack_tgl = ~link_q.ack_tgl;
         if (byte_shown)
         begin
            link_d.clk_en = 1'b1;
            link_d.first  = nb.first && !nb.parity;
            link_d.valid  = !nb.parity;
            link_d.last   = nb.last || nb.parity;
            if (nb.parity)
            begin
               link_d.err = 1'b0;
            end
            else if (nb.first)
            begin
               link_d.err = nb.err;
            end
            if (link_q.ser_s2)
            begin
               // msb now, the other seven follow from the shifter
               link_d.data    = {nb.data[7], tso_pkg::TSO_LOW_ZERO};
               link_d.shreg   = {nb.data[6:0], 1'b0};
               link_d.bit_cnt = tso_pkg::TSO_SER_LAST_BIT;
            end
            else
            begin
               // whole byte at once, stream bit 7 on the msb pin
               link_d.data = nb.data;
            end
         end
      end
      else if (link_q.last)
      begin
         // packet done and no byte taken this cycle (none queued, or the next first byte held back): close the window
         link_d.first = 1'b0;
         link_d.valid = 1'b0;
         link_d.err   = 1'b0;
         link_d.last  = 1'b0;
      end
   end

   // link flops share the async reset with the core
   always_ff @(posedge ts_link_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         link_q <= '{req_s1:  1'b0,
                     req_s2:  1'b0,
                     ack_tgl: 1'b0,
                     ser_s1:  1'b0,
                     ser_s2:  1'b0,
                     red_s1:  1'b0,
                     red_s2:  1'b0,
                     shreg:   tso_pkg::TSO_BYTE_ZERO,
                     bit_cnt: tso_pkg::TSO_CNT_ZERO,
                     data:    tso_pkg::TSO_BYTE_ZERO,
                     first:   1'b0,
                     valid:   1'b0,
                     err:     1'b0,
                     last:    1'b0,
                     clk_en:  1'b0};
      end
      else
      begin
         link_q <= link_d;
      end
   end

   // data clock pulses mid-bit; enable changes only while link clock is high
   assign ts_data_clock_o         = ~ts_link_clk_i & link_q.clk_en;

   // framing pins
   assign ts_byte_start_o         = link_q.first;
   assign packet_valid_window_o   = link_q.valid;
   assign packet_error_flag_o     = link_q.err;
   // data pins
   assign ts_msb_or_serial_line_o = link_q.data[7];
   assign ts_parallel_low_bits_o  = link_q.data[6:0];

endmodule : tso_output

//--- tso_output_properties.sv
// framing assertions on the transport stream pins
`timescale 1ns/1ps
module tso_output_properties
(
   // reset and link clock
   input wire logic       rstn_i,
   input wire logic       ts_link_clk_i,
   // mode level
   input wire logic       serial_mode_i,
   // framing and data pins
   input wire logic       ts_byte_start_o,
   input wire logic       packet_valid_window_o,
   input wire logic       packet_error_flag_o,
   input wire logic [6:0] ts_parallel_low_bits_o
);
   wire st = ts_byte_start_o, vw = packet_valid_window_o, ef = packet_error_flag_o;
   default clocking @(posedge ts_link_clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_ser_open; serial_mode_i && $rose(st); endsequence
   property p_st; st |-> vw; endproperty
   a_st: assert property (p_st) else $error("start off window");
   property p_ef; ef |-> vw; endproperty
   a_ef: assert property (p_ef) else $error("error off window");
   property p_op; $rose(vw) |-> st; endproperty
   a_op: assert property (p_op) else $error("window without start");
   property p_eu; $rose(ef) |-> st; endproperty
   a_eu: assert property (p_eu) else $error("error rose late");
   property p_eh; vw && !st |-> $stable(ef); endproperty
   a_eh: assert property (p_eh) else $error("error not held");
   property p_cl; $fell(vw) |-> !st && !ef; endproperty
   a_cl: assert property (p_cl) else $error("flags left up");
   property p_sl; serial_mode_i && vw |-> ts_parallel_low_bits_o == 7'h00; endproperty
   a_sl: assert property (p_sl) else $error("low bits in serial");
   property p_s8; s_ser_open |-> st[*8]; endproperty
   a_s8: assert property (p_s8) else $error("short serial start");
endmodule : tso_output_properties
bind tso_output tso_output_properties u_props (
   .rstn_i                 (rstn_i),
   .ts_link_clk_i          (ts_link_clk_i),
   .serial_mode_i          (serial_mode_i),
   .ts_byte_start_o        (ts_byte_start_o),
   .packet_valid_window_o  (packet_valid_window_o),
   .packet_error_flag_o    (packet_error_flag_o),
   .ts_parallel_low_bits_o (ts_parallel_low_bits_o)
);

//--- tso_pkg.sv
// shared types and constants for the transport stream output block
package tso_pkg;

   localparam logic [2:0] TSO_SER_LAST_BIT = 3'h7;
   localparam logic [2:0] TSO_CNT_ZERO     = 3'h0;
   localparam logic [7:0] TSO_BYTE_ZERO    = 8'h00;
   localparam logic       TSO_DIV_25MHZ    = 1'b0;
   localparam logic [2:0] TSO_CNT_STEP     = 3'h1;
   localparam logic [6:0] TSO_LOW_ZERO     = 7'h00;
   localparam logic [1:0] TSO_ARM_RST      = 2'h0;

   // one transport byte with its framing tags
   typedef struct packed {
      logic [7:0] data;
      logic       first;
      logic       last;
      logic       parity;
      logic       err;
   } tso_byte_t;

   localparam tso_byte_t TSO_BYTE_RST = '{data: 8'h00, first: 1'b0, last: 1'b0,
                                          parity: 1'b0, err: 1'b0};

   // core clock domain state
   typedef struct packed {
      tso_byte_t hold;
      logic      req_tgl;
      logic      ack_s1;
      logic      ack_s2;
      logic      busy;
      logic      strap_s1;
      logic      strap_s2;
      logic [1:0] strap_arm;
      logic      strap_done;
      logic      div_sel;
   } tso_core_t;

   // link clock domain state
   typedef struct packed {
      logic       req_s1;
      logic       req_s2;
      logic       ack_tgl;
      logic       ser_s1;
      logic       ser_s2;
      logic       red_s1;
      logic       red_s2;
      logic [7:0] shreg;
      logic [2:0] bit_cnt;
      logic [7:0] data;
      logic       first;
      logic       valid;
      logic       err;
      logic       last;
      logic       clk_en;
   } tso_link_t;

endpackage : tso_pkg

//--- tso_rx_model.sv
// receiver model sampling the transport stream pins
`timescale 1ns/1ps
module tso_rx_model
(
   // data clock from the port
   input  wire logic       data_clk_i,
   // mode level and pins
   input  wire logic       ser_i,
   input  wire logic       msb_i,
   input  wire logic       start_i,
   input  wire logic       err_i,
   input  wire logic [6:0] low_i,
   // captured results
   output logic [7:0]      first_o,
   output logic [7:0]      last_o,
   output logic [7:0]      cnt_o,
   output logic            err_o
);
   logic [2:0] nb  = 3'h0;
   logic [7:0] sh  = 8'h00;
   logic [7:0] cnt = 8'h00;
   assign cnt_o = cnt;
   always @(posedge data_clk_i)
   begin
      sh = {sh[6:0], msb_i};
      nb = ser_i ? nb + 3'h1 : 3'h0;
      if (!ser_i || nb == 3'h0)
      begin
         last_o = ser_i ? sh : {msb_i, low_i};
         cnt = cnt + 8'h01;
         if (start_i)
         begin
            first_o = last_o;
            err_o   = err_i;
         end
      end
   end
endmodule : tso_rx_model
